// ---- verilog/mrsc_defines.vh ----
`ifndef MRSC_DEFINES_VH
`define MRSC_DEFINES_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define MRSC_IDX_CFG_P0 12'h401
`define MRSC_IDX_CFG_P1 12'h801
`define MRSC_IDX_CFG_P2 12'hc01
`define MRSC_IDX_OVERSIZE_P0 12'h417
`define MRSC_IDX_OK_P0 12'h418
`define MRSC_IDX_CRC_ERROR_P0 12'h419
`define MRSC_IDX_MULTICAST_P0 12'h41a
`define MRSC_IDX_BROADCAST_P0 12'h41b
`define MRSC_IDX_PAUSE_P0 12'h41c
`define MRSC_IDX_OVERSIZE_P1 12'h817
`define MRSC_IDX_OK_P1 12'h818
`define MRSC_IDX_CRC_ERROR_P1 12'h819
`define MRSC_IDX_MULTICAST_P1 12'h81a
`define MRSC_IDX_BROADCAST_P1 12'h81b
`define MRSC_IDX_PAUSE_P1 12'h81c
`define MRSC_IDX_OVERSIZE_P2 12'hc17
`define MRSC_IDX_OK_P2 12'hc18
`define MRSC_IDX_CRC_ERROR_P2 12'hc19
`define MRSC_IDX_MULTICAST_P2 12'hc1a
`define MRSC_IDX_BROADCAST_P2 12'hc1b
`define MRSC_IDX_PAUSE_P2 12'hc1c

// ==========================================================
// Register decode fields
`define MRSC_PORT_BLOCK_P0 4'h4
`define MRSC_PORT_BLOCK_P1 4'h8
`define MRSC_PORT_BLOCK_P2 4'hc
`define MRSC_LOW_CFG 8'h01
`define MRSC_LOW_FIRST_COUNT 8'h17
`define MRSC_LOW_LAST_COUNT 8'h1c

// ==========================================================
// Field positions and reset values
`define MRSC_CFG_LONG_FRAME_BIT 3
`define MRSC_CFG_RESET 32'h0000_0000
`define MRSC_COUNT_RESET 32'h0000_0000
`define MRSC_COUNT_MAX 32'hffff_ffff

// ==========================================================
// Counter slots within one port
`define MRSC_SLOT_OVERSIZE 0
`define MRSC_SLOT_OK 1
`define MRSC_SLOT_CRC_ERROR 2
`define MRSC_SLOT_MULTICAST 3
`define MRSC_SLOT_BROADCAST 4
`define MRSC_SLOT_PAUSE 5
`define MRSC_SLOTS_PER_PORT 6
`define MRSC_PORTS 3

// ==========================================================
// Frame limits in bytes, then pause type and opcode values
`define MRSC_MAX_UNTAGGED 12'h5ee
`define MRSC_MAX_TAGGED 12'h5f2
`define MRSC_MAX_LONG 12'h800
`define MRSC_MIN_FRAME 12'h040
`define MRSC_PAUSE_TYPE 16'h8808
`define MRSC_PAUSE_OPCODE 16'h0001

`endif

// ---- verilog/mrsc_counters.v ----
// Contract
// - Jumbo off: max frame is 1518 untagged, 1522 tagged.
// - Jumbo bit 3 of port receive config set: max frame is 2048.
// - Oversize counts frames longer than max with valid FCS.
// - Max bytes plus a trailing partial byte is not oversize.
// - Every counter saturates at all ones, never wraps.
// - Reading a counter returns its value and clears it.
// - OK counts frames of legal length with no errors.
// - CRC error counts 64..max byte frames, bad FCS, no extra nibble.
// - Multicast counts good multicast frames, control included, not broadcast.
// - Broadcast counts good frames with broadcast destination.
// - Pause counts good frames with type 8808h and opcode 0001.
// - Three independent 32-bit counter sets at 04xxh, 08xxh, 0Cxxh.
// - FCS or symbol error makes a frame bad for good counters.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`include "mrsc_defines.vh"

module mrsc_counters (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [2:0] rx_frame_end,
  input wire [35:0] rx_frame_len,
  input wire [2:0] rx_extra_nibble,
  input wire [2:0] rx_fcs_error,
  input wire [2:0] rx_symbol_error,
  input wire [2:0] rx_vlan_tagged,
  input wire [2:0] rx_dest_multicast,
  input wire [2:0] rx_dest_broadcast,
  input wire [47:0] rx_type_field,
  input wire [47:0] rx_opcode,
  output reg [2:0] long_frame_enable
);

  localparam NCNT = `MRSC_PORTS * `MRSC_SLOTS_PER_PORT;

  reg [31:0] count [0:NCNT-1];
  reg [31:0] port_receive_config [0:2];
  wire [NCNT-1:0] count_inc;
  reg [NCNT-1:0] count_clear;

  // ==========================================================
  // Address decode
  wire [13:0] reg_index;
  wire [3:0] port_block;
  wire [7:0] low_index;
  reg port_hit;
  reg [1:0] port_sel;
  reg is_cfg;
  reg is_count;
  reg [4:0] count_sel;
  reg [7:0] count_off;

  assign reg_index = paddr[15:2];
  assign port_block = reg_index[11:8];
  assign low_index = reg_index[7:0];

  always @* begin
    port_hit = 1'b1;
    port_sel = 2'd0;
    case (port_block)
      `MRSC_PORT_BLOCK_P0: port_sel = 2'd0;
      `MRSC_PORT_BLOCK_P1: port_sel = 2'd1;
      `MRSC_PORT_BLOCK_P2: port_sel = 2'd2;
      default: port_hit = 1'b0;
    endcase
    if (reg_index[13:12] != 2'b00 || paddr[1:0] != 2'b00) begin
      port_hit = 1'b0;
    end
    is_cfg = port_hit && (low_index == `MRSC_LOW_CFG);
    is_count = port_hit && (low_index >= `MRSC_LOW_FIRST_COUNT) &&
               (low_index <= `MRSC_LOW_LAST_COUNT);
    count_off = low_index - `MRSC_LOW_FIRST_COUNT;
    count_sel = ({3'b000, port_sel} * 5'd6) + count_off[4:0];
  end

  // ==========================================================
  // APB slave: one wait state, answer registered
  wire access_first;
  wire access_done;

  assign access_first = psel && penable && !pready;
  assign access_done = psel && penable && pready;

  always @* begin
    count_clear = {NCNT{1'b0}};
    if (access_first && !pwrite && is_count) begin
      count_clear[count_sel] = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access_first;
      if (access_first) begin
        pslverr <= !(is_cfg || is_count);
        if (!pwrite && is_count) begin
          prdata <= count[count_sel];
        end else if (!pwrite && is_cfg) begin
          prdata <= port_receive_config[port_sel];
        end else begin
          prdata <= 32'h0000_0000;
        end
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Per-port config and frame classification
  genvar p;
  generate
    for (p = 0; p < `MRSC_PORTS; p = p + 1) begin : g_port
      wire [11:0] len;
      wire [11:0] max_len;
      wire bad;
      wire legal;
      wire good;
      wire pause;
      wire ev;

      assign len = rx_frame_len[p*12 +: 12];
      // Length is whole bytes only, so a trailing nibble never adds
      assign max_len = port_receive_config[p][`MRSC_CFG_LONG_FRAME_BIT] ?
                       `MRSC_MAX_LONG :
                       (rx_vlan_tagged[p] ? `MRSC_MAX_TAGGED :
                                            `MRSC_MAX_UNTAGGED);
      assign bad = rx_fcs_error[p] || rx_symbol_error[p];
      assign legal = (len >= `MRSC_MIN_FRAME) && (len <= max_len);
      assign good = legal && !bad;
      assign pause = (rx_type_field[p*16 +: 16] == `MRSC_PAUSE_TYPE) &&
                     (rx_opcode[p*16 +: 16] == `MRSC_PAUSE_OPCODE);
      assign ev = rx_frame_end[p];

      assign count_inc[p*6 + `MRSC_SLOT_OVERSIZE] =
        ev && (len > max_len) && !rx_fcs_error[p];
      assign count_inc[p*6 + `MRSC_SLOT_OK] = ev && good;
      assign count_inc[p*6 + `MRSC_SLOT_CRC_ERROR] =
        ev && legal && rx_fcs_error[p] && !rx_extra_nibble[p];
      assign count_inc[p*6 + `MRSC_SLOT_MULTICAST] =
        ev && good && rx_dest_multicast[p] && !rx_dest_broadcast[p];
      assign count_inc[p*6 + `MRSC_SLOT_BROADCAST] =
        ev && good && rx_dest_broadcast[p];
      assign count_inc[p*6 + `MRSC_SLOT_PAUSE] = ev && good && pause;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          port_receive_config[p] <= `MRSC_CFG_RESET;
        end else begin
          if (access_done && pwrite && is_cfg && port_sel == p) begin
            port_receive_config[p] <= pwdata;
          end
        end
      end
    end
  endgenerate

  // One driver for the output copy; it lags the config by one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      long_frame_enable <= 3'b000;
    end else begin
      long_frame_enable <= {
        port_receive_config[2][`MRSC_CFG_LONG_FRAME_BIT],
        port_receive_config[1][`MRSC_CFG_LONG_FRAME_BIT],
        port_receive_config[0][`MRSC_CFG_LONG_FRAME_BIT]};
    end
  end

  // ==========================================================
  // Saturating read-clear counters
  genvar c;
  generate
    for (c = 0; c < NCNT; c = c + 1) begin : g_count
      wire [31:0] base;
      // Event in the clearing cycle survives: clear first, then add
      assign base = count_clear[c] ? `MRSC_COUNT_RESET : count[c];
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          count[c] <= `MRSC_COUNT_RESET;
        end else if (count_inc[c] && base != `MRSC_COUNT_MAX) begin
          count[c] <= base + 32'h0000_0001;
        end else begin
          count[c] <= base;
        end
      end
    end
  endgenerate

endmodule // mrsc_counters

// ---- verif/mrsc_counters_props.sv ----
`timescale 1ns/1ns
// ======
// Port checks
module mrsc_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [2:0] long_frame_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire take = psel && penable && !pready;
  wire wr_end = pready && pwrite;
  wire [13:0] idx = paddr[15:2];
  chk_ready_next: assert property (take |=> pready)
    else $error("no ready");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready long");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("lone error");
  chk_unmapped_err: assert property (take && idx == 14'h0400 |=>
    pslverr && prdata == 32'h0) else $error("unmapped");
  chk_frag_err: assert property (take && idx == 14'h0c1d |=> pslverr)
    else $error("c1d mapped");
  chk_pause_map: assert property (take && idx == 14'h0c1c |=> !pslverr)
    else $error("c1c error");
  chk_jumbo_set: assert property (take && pwrite && idx == 14'h0801 |->
    ##[2:3] long_frame_enable[1] == pwdata[3]) else $error("jumbo");
  // Copy may lag one stage behind the config write
  chk_jumbo_hold: assert property ($changed(long_frame_enable) |->
    $past(wr_end) || $past(wr_end, 2)) else $error("jumbo moved");
  chk_rdata_hold: assert property (!psel && !pready |=> $stable(prdata))
    else $error("rdata moved");
  cover property (pready && !pwrite && !pslverr);
  cover property (pready && pslverr);
  cover property ($rose(long_frame_enable[1]));
endmodule // mrsc_checker
bind mrsc_counters mrsc_checker u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .long_frame_enable);

// ---- verif/mac_rx_stat_counters_tb_top.sv ----
`timescale 1ns/1ns
// ======
// Bench
module mac_rx_stat_counters_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, e;
  logic [2:0] fend = '0, nib = '0, fcs = '0, sym = '0, tag = '0;
  logic [2:0] mc = '0, bc = '0, lfe;
  logic [35:0] flen = '0;
  logic [47:0] ftype = '0, fop = '0;
  int failures = 0, n_checks = 0;
  always #50 pclk = ~pclk;
  mrsc_counters u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_frame_end(fend),
    .rx_frame_len(flen), .rx_extra_nibble(nib), .rx_fcs_error(fcs),
    .rx_symbol_error(sym), .rx_vlan_tagged(tag), .rx_dest_multicast(mc),
    .rx_dest_broadcast(bc), .rx_type_field(ftype), .rx_opcode(fop),
    .long_frame_enable(lfe));
  task chk(string nm, logic [31:0] x, logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      $display("CHECK FAILED %s exp %h got %h", nm, x, g);
      failures++;
    end
  endtask
  // Ready is sampled at the rising edge, request held until then
  task apb(bit w, logic [15:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) failures++;
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  function logic [15:0] ad(int p, int s);
    return 16'((p + 1) * 'h1000 + ('h17 + s) * 4);
  endfunction
  task rd(int p, int s, logic [31:0] x, string nm);
    apb(0, ad(p, s), '0);
    chk(nm, x, q);
  endtask
  // Flags: nibble fcs symbol tagged multicast broadcast pause
  task fr(int p, int len, logic [6:0] f);
    @(posedge pclk);
    fend[p] <= 1;
    flen[p*12+:12] <= 12'(len);
    {nib[p], fcs[p], sym[p], tag[p], mc[p], bc[p]} <= f[6:1];
    ftype[p*16+:16] <= f[0] ? 16'h8808 : 16'h0800;
    fop[p*16+:16] <= {15'h0, f[0]};
    @(posedge pclk);
    fend <= '0;
  endtask
  task t_reset;
    for (int p = 0; p < 3; p++) begin
      for (int s = 0; s < 6; s++) rd(p, s, 0, "reset");
    end
    apb(0, 16'h1000, '0);
    chk("slverr", 1, e);
    apb(0, 16'h3074, '0);
    chk("slverr c1d", 1, e);
  endtask
  task t_limits;
    fr(0, 1518, 7'h00);
    fr(0, 1522, 7'h08);
    fr(0, 1519, 7'h00);
    fr(0, 1523, 7'h08);
    fr(0, 1519, 7'h20);
    fr(0, 1518, 7'h40);
    fr(0, 64, 7'h20);
    fr(0, 64, 7'h60);
    fr(0, 63, 7'h00);
    fr(0, 100, 7'h10);
    rd(0, 0, 2, "ovr");
    rd(0, 1, 3, "ok");
    rd(0, 2, 1, "crc");
  endtask
  task t_jumbo;
    apb(1, 16'h2004, 32'h8);
    repeat (2) @(negedge pclk);
    chk("lfe", 3'h2, lfe);
    fr(1, 2048, 7'h00);
    fr(1, 2049, 7'h00);
    rd(1, 1, 1, "ok1");
    rd(1, 0, 1, "ovr1");
  endtask
  task t_class;
    fr(2, 64, 7'h04);
    fr(2, 64, 7'h06);
    fr(2, 64, 7'h05);
    fr(2, 64, 7'h25);
    rd(2, 3, 2, "mc");
    rd(2, 4, 1, "bc");
    rd(2, 5, 1, "pause");
    rd(2, 1, 3, "ok2");
  endtask
  task t_clear;
    rd(2, 3, 0, "mc clr");
    fr(2, 64, 7'h04);
    apb(1, ad(2, 3), 32'h5);
    rd(2, 3, 1, "mc wr");
  endtask
  task test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_limits;
    t_jumbo;
    t_class;
    t_clear;
    test_done;
  end
  initial begin
    #200000;
    failures++;
    test_done;
  end
endmodule // mac_rx_stat_counters_tb_top
